// ---- rtl/serial_frame_port_map.vh ----
// constants for the framed serial port
// Functional notes
// - capture serial_in on serial clock falling edges
// - frame select low: accept sixteen falling edges
// - reset low asynchronously restores default configuration
// - launch output bits on rising edges
// - output MSB appears when frame select falls
// - advance only after falling edge within frame
// - output carries conversion, readback, temperature data
// - eight multifunction pins configured independently
// - pin seven may show conversion busy
`ifndef SERIAL_FRAME_PORT_MAP_VH
`define SERIAL_FRAME_PORT_MAP_VH
`define FRAME_BITS        16
`define CNT_W             5
`define PIN_COUNT         8
`define PIN_MODE_W        3
// pin modes
`define MODE_OFF          3'h0
`define MODE_DAC          3'h1
`define MODE_ADC          3'h2
`define MODE_DIN          3'h3
`define MODE_DOUT         3'h4
`define MODE_BUSY         3'h5
// reset values
`define PIN_MODES_RST     24'h00_0000
`define DOUT_RST          8'h00
`define SHIFT_RST         16'h0000
`endif

// ---- rtl/pin_sync.v ----
// two-flop synchroniser for a bus of asynchronous inputs
`timescale 1ns/1ns
module pin_sync #(
  parameter W = 1
) (
  // clock and reset
  input  wire         clk,
  input  wire         rstn,
  // asynchronous in, synchronous out
  input  wire [W-1:0] async_in,
  output reg  [W-1:0] sync_out
);
  reg [W-1:0] meta_reg;

  // first stage feeds only the second
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      meta_reg <= {W{1'b0}};
      sync_out <= {W{1'b0}};
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end
endmodule // pin_sync

// ---- rtl/serial_frame_port.v ----
// framed 16-bit serial port with multifunction pin steering
`timescale 1ns/1ns
`include "serial_frame_port_map.vh"
module serial_frame_port #(
  parameter FRAME_BITS = `FRAME_BITS
) (
  // clock and reset
  input  wire                                    clk,
  input  wire                                    rstn,
  // serial pins from the host
  input  wire                                    sclk,
  input  wire                                    frame_n,
  input  wire                                    serial_in,
  output reg                                     serial_out,
  // received frame to the core
  output reg  [FRAME_BITS-1:0]                   rx_word,
  output reg                                     rx_valid,
  // readback word from the core, sampled at frame start
  input  wire [FRAME_BITS-1:0]                   tx_word,
  // pin configuration and core data
  input  wire [`PIN_COUNT*`PIN_MODE_W-1:0]       pin_modes,
  input  wire [`PIN_COUNT-1:0]                   pin_dout,
  input  wire                                    conv_busy,
  output reg  [`PIN_COUNT-1:0]                   pin_din,
  // multifunction pins
  input  wire [`PIN_COUNT-2:0]                   multi_pins_low_i,
  output reg  [`PIN_COUNT-2:0]                   multi_pins_low_o,
  output reg  [`PIN_COUNT-2:0]                   multi_pins_low_oe,
  input  wire                                    multi_pin_seven_i,
  output reg                                     multi_pin_seven_o,
  output reg                                     multi_pin_seven_oe,
  // analog routing enables for the converters
  output reg  [`PIN_COUNT-1:0]                   dac_en,
  output reg  [`PIN_COUNT-1:0]                   adc_en
);
  // -----------------------------------------------------------------
  // input synchronisation
  // -----------------------------------------------------------------
  wire [2:0]            ser_s;
  wire [`PIN_COUNT-1:0] pins_s;
  wire                  sclk_s    = ser_s[2];
  // select travels inverted so a reset synchroniser reads as deselected, not as a false frame start
  wire                  frame_n_s = ~ser_s[1];
  wire                  sdi_s     = ser_s[0];

  pin_sync #(.W(3)) u_ser_sync (
    .clk      (clk),
    .rstn     (rstn),
    .async_in ({sclk, ~frame_n, serial_in}),
    .sync_out (ser_s)
  );

  pin_sync #(.W(`PIN_COUNT)) u_pin_sync (
    .clk      (clk),
    .rstn     (rstn),
    .async_in ({multi_pin_seven_i, multi_pins_low_i}),
    .sync_out (pins_s)
  );

  // -----------------------------------------------------------------
  // edge detection
  // -----------------------------------------------------------------
  reg        sclk_d_reg;
  reg        frame_d_reg;
  wire       sclk_fall  = sclk_d_reg & ~sclk_s;
  wire       sclk_rise  = ~sclk_d_reg & sclk_s;
  wire       frame_fall = frame_d_reg & ~frame_n_s;

  // delayed copies, taken from the second flop only
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sclk_d_reg  <= 1'b0;
      frame_d_reg <= 1'b1;
    end else begin
      sclk_d_reg  <= sclk_s;
      frame_d_reg <= frame_n_s;
    end
  end

  // -----------------------------------------------------------------
  // frame engine
  // -----------------------------------------------------------------
  reg [FRAME_BITS-1:0] shift_in_reg;
  reg [FRAME_BITS-1:0] shift_out_reg;
  reg [`CNT_W-1:0]     bit_cnt_reg;
  reg                  fell_seen_reg;
  reg                  active_reg;
  wire                 last_bit = (bit_cnt_reg == FRAME_BITS[`CNT_W-1:0] - 1'b1);

  // whole frame logic resets asynchronously to defaults
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      shift_in_reg  <= `SHIFT_RST;
      shift_out_reg <= `SHIFT_RST;
      bit_cnt_reg   <= {`CNT_W{1'b0}};
      fell_seen_reg <= 1'b0;
      active_reg    <= 1'b0;
      serial_out    <= 1'b0;
      rx_word       <= `SHIFT_RST;
      rx_valid      <= 1'b0;
    end else begin
      rx_valid <= 1'b0;
      if (frame_n_s) begin
        // deselected: clock and data ignored, shifter held
        active_reg    <= 1'b0;
        fell_seen_reg <= 1'b0;
      end else if (frame_fall) begin
        // load readback word, msb out before any clock edge
        active_reg    <= 1'b1;
        bit_cnt_reg   <= {`CNT_W{1'b0}};
        fell_seen_reg <= 1'b0;
        shift_out_reg <= {tx_word[FRAME_BITS-2:0], 1'b0};
        serial_out    <= tx_word[FRAME_BITS-1];
      end else if (active_reg) begin
        if (sclk_fall) begin
          // sample on falling edge; sixteenth edge closes the frame
          shift_in_reg  <= {shift_in_reg[FRAME_BITS-2:0], sdi_s};
          fell_seen_reg <= 1'b1;
          bit_cnt_reg   <= bit_cnt_reg + 1'b1;
          if (last_bit) begin
            active_reg <= 1'b0;
            rx_word    <= {shift_in_reg[FRAME_BITS-2:0], sdi_s};
            rx_valid   <= 1'b1;
          end
        end else if (sclk_rise && fell_seen_reg) begin
          // idle-low clock gives an early rise; it is skipped
          serial_out    <= shift_out_reg[FRAME_BITS-1];
          shift_out_reg <= {shift_out_reg[FRAME_BITS-2:0], 1'b0};
          fell_seen_reg <= 1'b0;
        end
      end
    end
  end

  // -----------------------------------------------------------------
  // multifunction pins, one slice per pin
  // -----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < `PIN_COUNT; g = g + 1) begin : g_pin
      wire [`PIN_MODE_W-1:0] mode = pin_modes[g*`PIN_MODE_W +: `PIN_MODE_W];
      wire busy_mode = (g == `PIN_COUNT-1) && (mode == `MODE_BUSY);
      wire drv  = (mode == `MODE_DOUT) || busy_mode;
      wire val  = busy_mode ? conv_busy : pin_dout[g];

      // each pin steered on its own mode only
      always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
          dac_en[g]  <= 1'b0;
          adc_en[g]  <= 1'b0;
          pin_din[g] <= 1'b0;
        end else begin
          dac_en[g]  <= (mode == `MODE_DAC);
          adc_en[g]  <= (mode == `MODE_ADC);
          pin_din[g] <= (mode == `MODE_DIN) ? pins_s[g] : 1'b0;
        end
      end

      if (g == `PIN_COUNT-1) begin : g_top
        always @(posedge clk or negedge rstn) begin
          if (!rstn) begin
            multi_pin_seven_o  <= 1'b0;
            multi_pin_seven_oe <= 1'b0;
          end else begin
            multi_pin_seven_o  <= val;
            multi_pin_seven_oe <= drv;
          end
        end
      end else begin : g_low
        always @(posedge clk or negedge rstn) begin
          if (!rstn) begin
            multi_pins_low_o[g]  <= 1'b0;
            multi_pins_low_oe[g] <= 1'b0;
          end else begin
            multi_pins_low_o[g]  <= val;
            multi_pins_low_oe[g] <= drv;
          end
        end
      end
    end
  endgenerate
endmodule // serial_frame_port

// ---- verif/serial_frame_port_assertions.sv ----
// concurrent checks on the framed serial port pins
`timescale 1ns/1ns
module sfp_checker #(parameter FRAME_BITS = 16) (
  // clock, reset and serial pins
  input logic                  clk, rstn, sclk, frame_n, serial_out,
  // core side
  input logic [FRAME_BITS-1:0] tx_word,
  input logic                  rx_valid, conv_busy, multi_pin_seven_o, multi_pin_seven_oe,
  input logic [23:0]           pin_modes,
  input logic [7:0]            pin_din, dac_en, adc_en
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  // ------------------------------
  // frame start, word output, reset and pin checks
  // ------------------------------
  sequence frame_start; $fell(frame_n); endsequence
  // the synchroniser costs up to four clocks before the first bit shows
  sequence msb_shown; ##[2:4] serial_out == tx_word[FRAME_BITS-1]; endsequence
  a_msb_on_select: assert property (frame_start |-> msb_shown) else $error("msb not shown");
  a_valid_pulse: assert property (rx_valid |=> !rx_valid) else $error("rx_valid too long");
  a_valid_in_frame: assert property (rx_valid |-> !$past(frame_n, 4)) else $error("word outside frame");
  a_idle_quiet: assert property (frame_n[*8] |-> !rx_valid) else $error("word while idle");
  a_hold_high: assert property ((sclk && !frame_n)[*8] |-> $stable(serial_out)) else $error("bit moved");
  a_hold_low: assert property ((!sclk && !frame_n)[*8] |-> $stable(serial_out)) else $error("bit moved");
  a_reset_clear: assert property (disable iff (1'b0) (!rstn ##1 !rstn) |-> !rx_valid && !serial_out && dac_en == 8'h00)
    else $error("reset left state");
  a_din_gate: assert property ((pin_modes[2:0] != 3'h3)[*4] |-> !pin_din[0]) else $error("din leak");
  a_dac_decode: assert property ((pin_modes[5:3] == 3'h1)[*4] |-> dac_en[1] && !adc_en[1])
    else $error("dac decode");
  a_busy_pin: assert property ((pin_modes[23:21] == 3'h5 && conv_busy)[*6] |-> multi_pin_seven_oe && multi_pin_seven_o)
    else $error("busy not shown");
endmodule // sfp_checker
bind serial_frame_port sfp_checker #(.FRAME_BITS(FRAME_BITS)) chk_u (.*);

// ---- verif/host_model.sv ----
// host controller model driving the serial frame pins
`timescale 1ns/1ns
module host_model (
  // serial pins
  output logic sclk, frame_n, serial_in,
  input  logic serial_out
);
  initial begin
    sclk = 1'b0;
    frame_n = 1'b1;
    serial_in = 1'b0;
  end
  // one frame of n bits, msb first; the 80 ns clock stays within the readout limit
  task automatic xfer(input logic [15:0] w, input int n, output logic [15:0] r);
    r = 16'h0000;
    frame_n = 1'b0;
    #80;
    for (int i = 0; i < n; i++) begin
      serial_in = w[15-i];
      sclk = 1'b1;
      #(i == 0 ? 80 : 40);
      r[15-i] = serial_out;
      sclk = 1'b0;
      #40;
    end
    #40;
    frame_n = 1'b1;
    serial_in = ~serial_in; // a released line must not keep its last bit
    #80;
  endtask
  // clock and data wiggle while deselected
  task automatic noise();
    repeat (4) begin
      serial_in = ~serial_in;
      sclk = 1'b1;
      #40;
      sclk = 1'b0;
      #40;
    end
  endtask
endmodule // host_model

// ---- verif/tb_top.sv ----
// self-checking bench for the framed serial port
`timescale 1ns/1ns
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin mismatches++; \
  $display("Error at %0t: got %h expected %h", $time, a, b); end end
module tb_top;
  logic        clk = 1'b0, rstn = 1'b0, conv_busy = 1'b0, multi_pin_seven_i = 1'b0;
  logic [15:0] tx_word = 16'h0000, rx_word, r;
  logic [23:0] pin_modes = 24'h00_0000;
  logic [7:0]  pin_dout = 8'h00, pin_din, dac_en, adc_en;
  logic [6:0]  multi_pins_low_i = 7'h00, multi_pins_low_o, multi_pins_low_oe;
  logic        sclk, frame_n, serial_in, serial_out, rx_valid, multi_pin_seven_o, multi_pin_seven_oe;
  int          mismatches = 0, num_checks = 0, vcnt = 0;
  always #4 clk = ~clk;
  // count received words so a lost or doubled word shows
  always @(posedge clk) if (rx_valid) vcnt <= vcnt + 1;
  host_model host_u (.sclk(sclk), .frame_n(frame_n), .serial_in(serial_in), .serial_out(serial_out));
  serial_frame_port dut_u (.*);
  task automatic t_frame();
    tx_word = 16'hA5C3;
    vcnt = 0;
    host_u.xfer(16'h3C5A, 16, r);
    `CHK(r, 16'hA5C3)
    `CHK(rx_word, 16'h3C5A)
    `CHK(vcnt, 1)
    $display("test frame done");
  endtask
  task automatic t_abort();
    vcnt = 0;
    host_u.xfer(16'hFFFF, 8, r);
    host_u.noise();
    `CHK(vcnt, 0)
    `CHK(rx_word, 16'h3C5A)
    host_u.xfer(16'h1234, 16, r);
    `CHK(rx_word, 16'h1234)
    `CHK(vcnt, 1)
    $display("test abort done");
  endtask
  task automatic t_pins();
    pin_modes = 24'hA0_088B;
    pin_dout = 8'h08;
    multi_pins_low_i = 7'h01;
    conv_busy = 1'b1;
    repeat (8) @(negedge clk);
    `CHK(pin_din, 8'h01)
    `CHK({dac_en, adc_en}, 16'h0204)
    `CHK({multi_pins_low_oe[3], multi_pins_low_o[3]}, 2'b11)
    `CHK({multi_pin_seven_oe, multi_pin_seven_o}, 2'b11)
    conv_busy = 1'b0;
    repeat (8) @(negedge clk);
    `CHK(multi_pin_seven_o, 1'b0)
    rstn = 1'b0;
    #1;
    `CHK({dac_en, adc_en, pin_din}, 24'h00_0000)
    $display("test pins done");
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    repeat (4) @(negedge clk);
    `CHK({serial_out, rx_valid, rx_word}, 18'h0_0000)
    rstn = 1'b1;
    repeat (4) @(negedge clk);
    t_frame();
    t_abort();
    t_pins();
    final_report();
  end
  initial begin
    #100000;
    mismatches++;
    final_report();
  end
endmodule // tb_top
